// [hdl/sbg_params.svh]
// register offsets, field positions, reset values and timing counts
`ifndef SBG_PARAMS_SVH
`define SBG_PARAMS_SVH
`define SBG_OFF_BAUD_HI     12'h000
`define SBG_OFF_BAUD_LO     12'h004
`define SBG_OFF_CTRL        12'h008
`define SBG_OFF_STATUS      12'h00c
`define SBG_OFF_MASK        12'h010
`define SBG_OFF_TXDATA      12'h014
`define SBG_OFF_RXDATA      12'h018
`define SBG_HI_BRK_IE_BIT   7
`define SBG_HI_EDGE_IE_BIT  6
`define SBG_LO_RESET        8'h04
`define SBG_CTRL_RX_ON      0
`define SBG_CTRL_TX_ON      1
`define SBG_CTRL_NINE       2
`define SBG_CTRL_SEND_BRK   3
`define SBG_CTRL_BRK_DET_EN 4
`define SBG_CTRL_PIN_POS    5
`define SBG_ST_BRK          0
`define SBG_ST_EDGE         1
`define SBG_ST_RXFULL       2
`define SBG_ST_TXEMPTY      3
`define SBG_OVERSAMPLE      16
`define SBG_BRK_TX_BITS     13
`define SBG_BRK_RX_BITS     11
`endif

// [hdl/sbg_pkg.sv]
// types shared by the baud generator block
package sbg_pkg;
    typedef enum logic [2:0] {
        SBG_TX_IDLE = 3'b001,
        SBG_TX_SHIFT = 3'b010,
        SBG_TX_BREAK = 3'b100
    } sbg_tx_state_t;
endpackage : sbg_pkg

// [hdl/sbg_baud_gen.sv]
// baud generator, divisor registers and minimal nrz shifters on apb
`include "sbg_params.svh"
module sbg_baud_gen
    import sbg_pkg::*;
#(
    parameter int DIV_W = 13
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // interrupt
    output logic             irq,
    // default pin pair
    output logic             serial_out_pin_dflt,
    input  wire logic        serial_in_pin_dflt,
    // alternate pin pair
    output logic             serial_out_pin_alt,
    input  wire logic        serial_in_pin_alt,
    // oversampling tick
    output logic             baud_tick
);
    // the field split and the counter compare assume this width
    if (DIV_W != 13) begin : g_div_w_check
        $error("sbg_baud_gen: DIV_W must be 13");
    end

    // ****************
    // registers
    // ****************
    logic [7:0]       baud_high_and_irq_enables;
    logic [7:0]       baud_low_divisor;
    logic [4:0]       hi_buf;
    logic [5:0]       ctrl;
    logic [3:0]       status;
    logic [3:0]       mask;
    logic             gen_armed;
    logic [8:0]       tx_buf;
    logic             tx_buf_full;
    logic [8:0]       rx_buf;
    logic             rx_buf_full;


    // ****************
    // decode
    // ****************
    wire logic setup    = psel & ~penable;
    wire logic acc      = psel & penable;
    wire logic wr       = acc & pwrite;
    wire logic rd       = acc & ~pwrite;
    wire logic hit_hi   = paddr == `SBG_OFF_BAUD_HI;
    wire logic hit_lo   = paddr == `SBG_OFF_BAUD_LO;
    wire logic hit_ctl  = paddr == `SBG_OFF_CTRL;
    wire logic hit_st   = paddr == `SBG_OFF_STATUS;
    wire logic hit_msk  = paddr == `SBG_OFF_MASK;
    wire logic hit_tx   = paddr == `SBG_OFF_TXDATA;
    wire logic hit_rx   = paddr == `SBG_OFF_RXDATA;
    wire logic mapped   = hit_hi | hit_lo | hit_ctl | hit_st | hit_msk
                        | hit_tx | hit_rx;
    wire logic [DIV_W-1:0] divisor_value =
        {baud_high_and_irq_enables[4:0], baud_low_divisor};
    wire logic rx_on    = ctrl[`SBG_CTRL_RX_ON];
    wire logic tx_on    = ctrl[`SBG_CTRL_TX_ON];
    wire logic pin_position_select = ctrl[`SBG_CTRL_PIN_POS];
    wire logic gen_run  = gen_armed & (divisor_value != '0);
    wire logic serial_in = pin_position_select ? serial_in_pin_alt
                                               : serial_in_pin_dflt;

    // ****************
    // apb access
    // ****************
    // no wait state: answer in the cycle after setup
    // unmapped or unaligned addresses answer with pslverr and read 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= 32'h0;
            if (setup) begin
                unique case (1'b1)
                    hit_hi:  prdata <= {24'h0, baud_high_and_irq_enables};
                    hit_lo:  prdata <= {24'h0, baud_low_divisor};
                    hit_ctl: prdata <= {26'h0, ctrl};
                    hit_st:  prdata <= {28'h0, status};
                    hit_msk: prdata <= {28'h0, mask};
                    hit_rx:  prdata <= {23'h0, rx_buf};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    wire logic wdone = wr & pready;
    wire logic rdone = rd & pready;

    // ****************
    // register writes
    // ****************
    // high write sets the enables and fills hi_buf with its divisor bits, so a half-written divisor never runs

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_high_and_irq_enables <= 8'h00;
            baud_low_divisor <= `SBG_LO_RESET;
            hi_buf    <= 5'h00;
            ctrl      <= 6'h00;
            mask      <= 4'h0;
            gen_armed <= 1'b0;
        end else begin
            if (wdone && hit_hi) begin
                // enables act at once; divisor part only buffered
                baud_high_and_irq_enables[7:5] <= pwdata[7:5];
                hi_buf <= pwdata[4:0];
            end
            if (wdone && hit_lo) begin
                baud_low_divisor <= pwdata[7:0];
                baud_high_and_irq_enables[4:0] <= hi_buf;
            end
            if (wdone && hit_ctl) begin
                ctrl <= pwdata[5:0];
                if (pwdata[`SBG_CTRL_RX_ON] | pwdata[`SBG_CTRL_TX_ON])
                    gen_armed <= 1'b1;
            end
            if (wdone && hit_msk)
                mask <= pwdata[3:0];
        end
    end

    // ****************
    // baud generator
    // ****************
    // cleared while stopped, so the divider does not toggle
    logic [DIV_W-1:0] cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt       <= '0;
            baud_tick <= 1'b0;
        end else if (!gen_run) begin
            cnt       <= '0;
            baud_tick <= 1'b0;
        // reload at one: a tick every divisor_value clocks
        end else if (cnt <= 13'h0001) begin
            cnt       <= divisor_value;
            baud_tick <= 1'b1;
        end else begin
            cnt       <= cnt - 13'h0001;
            baud_tick <= 1'b0;
        end
    end

    // ****************
    // transmitter
    // ****************
    sbg_tx_state_t tx_state;
    logic [3:0]  tx_sub;
    logic [3:0]  tx_bit;
    logic [10:0] tx_sh;
    wire logic nine = ctrl[`SBG_CTRL_NINE];
    wire logic [3:0] tx_len = nine ? 4'hb : 4'ha;
    wire logic bit_end = baud_tick & (tx_sub == 4'hf);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= SBG_TX_IDLE;
            tx_sub <= 4'h0;
            tx_bit <= 4'h0;
            tx_sh  <= 11'h7ff;
            tx_buf_full <= 1'b0;
            tx_buf <= 9'h000;
            serial_out_pin_dflt <= 1'b1;
            serial_out_pin_alt  <= 1'b1;
        end else begin
            serial_out_pin_dflt <= pin_position_select | tx_sh[0];
            serial_out_pin_alt  <= ~pin_position_select | tx_sh[0];
            if (baud_tick)
                tx_sub <= tx_sub + 4'h1;
            unique case (tx_state)
                SBG_TX_IDLE: begin
                    tx_sh <= 11'h7ff;
                    tx_bit <= 4'h0;
                    if (tx_on && bit_end && ctrl[`SBG_CTRL_SEND_BRK]) begin
                        tx_sh <= 11'h000;
                        tx_state <= SBG_TX_BREAK;
                    end else if (tx_on && bit_end && tx_buf_full) begin
                        tx_sh <= nine ? {1'b1, tx_buf, 1'b0}
                                      : {2'b11, tx_buf[7:0], 1'b0};
                        tx_buf_full <= 1'b0;
                        tx_state <= SBG_TX_SHIFT;
                    end
                end
                SBG_TX_SHIFT: if (bit_end) begin
                    tx_sh <= {1'b1, tx_sh[10:1]};
                    tx_bit <= tx_bit + 4'h1;
                    if (tx_bit == tx_len - 4'h1)
                        tx_state <= SBG_TX_IDLE;
                end
                // a break runs its full length once started
                SBG_TX_BREAK: if (bit_end) begin
                    tx_bit <= tx_bit + 4'h1;
                    if (tx_bit == 4'(`SBG_BRK_TX_BITS - 1)) begin
                        tx_sh <= 11'h7ff;
                        tx_state <= SBG_TX_IDLE;
                    end
                end
            endcase
            // a write in the load cycle wins: the buffer takes the new
            // word while the shifter takes the old one
            if (wdone && hit_tx) begin
                tx_buf <= pwdata[8:0];
                tx_buf_full <= 1'b1;
            end
        end
    end

    // ****************
    // receiver and events
    // ****************
    // rx_prev resets to the idle level, so reset makes no false edge
    logic        rx_prev;
    logic        rx_busy;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_bit;
    logic [8:0]  rx_sh;
    logic [7:0]  low_cnt;
    wire logic fall = rx_prev & ~serial_in;
    wire logic mid  = baud_tick & (rx_sub == 4'h7);
    // one tick only: low_cnt has moved past the count by the next tick
    wire logic brk_evt = ctrl[`SBG_CTRL_BRK_DET_EN] & baud_tick & ~serial_in
        & (low_cnt == 8'(`SBG_BRK_RX_BITS * `SBG_OVERSAMPLE - 1));
    wire logic rx_done = rx_busy & mid & (rx_bit == tx_len - 4'h1);
    wire logic [3:0] set_ev = {~tx_buf_full, rx_done, rx_on & fall,
                               brk_evt};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_prev <= 1'b1;
            rx_busy <= 1'b0;
            rx_sub  <= 4'h0;
            rx_bit  <= 4'h0;
            rx_sh   <= 9'h000;
            rx_buf  <= 9'h000;
            rx_buf_full <= 1'b0;
            low_cnt <= 8'h00;
            status  <= 4'h0;
            irq     <= 1'b0;
        end else begin
            rx_prev <= serial_in;
            if (serial_in)
                low_cnt <= 8'h00;
            else if (baud_tick && low_cnt != 8'hff)
                low_cnt <= low_cnt + 8'h01;
            if (baud_tick)
                rx_sub <= rx_sub + 4'h1;
            if (!rx_busy && rx_on && fall) begin
                rx_busy <= 1'b1;
                rx_sub  <= 4'h0;
                rx_bit  <= 4'h0;
            end else if (rx_busy && mid) begin
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit != 4'h0)
                    rx_sh <= nine ? {serial_in, rx_sh[8:1]}
                                  : {1'b0, serial_in, rx_sh[7:1]};
                if (rx_done) begin
                    rx_busy <= 1'b0;
                    rx_buf  <= rx_sh;
                    rx_buf_full <= 1'b1;
                end
            end
            if (rdone && hit_rx && !rx_done)
                rx_buf_full <= 1'b0;
            // a set in the same cycle as a write-one clear wins
            status <= (status & ~((wdone && hit_st) ? pwdata[3:0] : 4'h0))
                    | set_ev;
            irq <= |(status & mask)
                 | (baud_high_and_irq_enables[`SBG_HI_BRK_IE_BIT]
                    & status[`SBG_ST_BRK])
                 | (baud_high_and_irq_enables[`SBG_HI_EDGE_IE_BIT]
                    & status[`SBG_ST_EDGE]);
        end
    end
endmodule : sbg_baud_gen

// [dv/sbg_sva.sv]
// port checker for the baud generator
`include "sbg_params.svh"
// ****************************************
// checker
// ****************************************
module sbg_sva (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins and tick
    input wire logic        serial_out_pin_dflt,
    input wire logic        serial_out_pin_alt,
    input wire logic        baud_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        armed;
    logic [4:0]  hi_shadow;
    logic [12:0] div_shadow;
    wire logic   wr_done = psel && penable && pready && pwrite;
    // arming sticks, so later control writes cannot disarm the tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed      <= 1'b0;
            hi_shadow  <= 5'h00;
            div_shadow <= {5'h00, `SBG_LO_RESET};
        end else if (wr_done) begin
            if (paddr == `SBG_OFF_CTRL && |pwdata[1:0])
                armed <= 1'b1;
            if (paddr == `SBG_OFF_BAUD_HI)
                hi_shadow <= pwdata[4:0];
            // the low write commits the buffered high part as well
            if (paddr == `SBG_OFF_BAUD_LO)
                div_shadow <= {hi_shadow, pwdata[7:0]};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_CAUSE: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("ready without setup");
    AST_UNMAPPED: assert property (pready && paddr >= 12'h01c
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (pready && paddr <= 12'h018
        && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    AST_IDLE_OUT: assert property (!$past(presetn) |->
        serial_out_pin_dflt && serial_out_pin_alt)
        else $error("line not idle after reset");
    AST_ONE_PAIR: assert property (serial_out_pin_dflt || serial_out_pin_alt)
        else $error("both pin pairs driven");
    AST_UNARMED: assert property (!armed |-> !baud_tick)
        else $error("tick before arming");
    // a divisor of one ticks every cycle, so it is left out
    AST_TICK_PULSE: assert property (baud_tick &&
        div_shadow != 13'h0001 && $past(div_shadow) != 13'h0001
        |=> !baud_tick)
        else $error("tick wider than one cycle");
    AST_ZERO_STOP: assert property (div_shadow == 13'h0000 &&
        $past(div_shadow) == 13'h0000 |-> !baud_tick)
        else $error("tick with zero divisor");
endmodule : sbg_sva
bind sbg_baud_gen sbg_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_out_pin_dflt,
    .serial_out_pin_alt, .baud_tick);

// [dv/sbg_node.sv]
// remote serial node on the far side of the pins
// ****************************************
// node
// ****************************************
module sbg_node (
    // line from and to the block
    input  wire logic pclk,
    input  wire logic rx_line,
    output logic      tx_line
);
    timeunit 1ns;
    timeprecision 1ns;
    initial tx_line = 1'b1;
    // low stretch; the line has a pull-up, so release means high
    task automatic hold_low(input int clks);
        @(posedge pclk) tx_line <= 1'b0;
        repeat (clks) @(posedge pclk);
        tx_line <= 1'b1;
    endtask : hold_low
    // nrz character, lsb first, one stop bit; bc clocks a bit
    task automatic put_char(input int bc, input int nb,
                            input logic [8:0] d);
        @(posedge pclk) tx_line <= 1'b0;
        repeat (bc) @(posedge pclk);
        for (int i = 0; i < nb; i++) begin
            tx_line <= d[i];
            repeat (bc) @(posedge pclk);
        end
        tx_line <= 1'b1;
        repeat (bc) @(posedge pclk);
    endtask : put_char
    // mid-bit sampling tolerates a coarse start phase; stop lands at nb
    task automatic get_char(input int bc, input int nb,
                            output logic [9:0] ch);
        int w;
        w = 0;
        while (rx_line !== 1'b0 && w < 20000) begin
            @(posedge pclk);
            w++;
        end
        repeat (bc / 2) @(posedge pclk);
        for (int i = 0; i <= nb; i++) begin
            repeat (bc) @(posedge pclk);
            ch[i] = rx_line;
        end
    endtask : get_char
endmodule : sbg_node

// [dv/sbg_baud_gen_tb.sv]
// self-checking bench for the baud generator
`include "sbg_params.svh"
module sbg_baud_gen_tb
    import sbg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic        pwrite = 0, pos = 0, er, pready, pslverr, irq, od, oa;
    logic        tick, nl;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    int          bad_count = 0, cmp_count = 0, n, w;
    always #10 pclk = ~pclk;
    sbg_baud_gen u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq,
        // the deselected input idles high, as its pull-up would hold it
        .serial_out_pin_dflt(od), .serial_in_pin_dflt(pos ? 1'b1 : nl),
        .serial_out_pin_alt(oa), .serial_in_pin_alt(pos ? nl : 1'b1),
        .baud_tick(tick));
    sbg_node u_node (.pclk, .rx_line(pos ? oa : od), .tx_line(nl));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string s, input logic [31:0] v, e);
        cmp_count++;
        if (v !== e) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", s, e, v);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        if (pready !== 1'b1)
            bad_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic period(output int p);
        int k;
        k = 0;
        p = 1;
        while (tick !== 1'b1 && k < 9000) begin
            @(posedge pclk);
            k++;
        end
        @(posedge pclk);
        while (tick !== 1'b1 && p < 9000) begin
            @(posedge pclk);
            p++;
        end
    endtask : period
    task automatic no_ticks();
        int k;
        k = 0;
        repeat (300) @(posedge pclk) if (tick === 1'b1) k++;
        chk("ticks", k, 0);
    endtask : no_ticks
    task automatic irq_is(input logic e);
        repeat (2) @(posedge pclk);
        chk("irq", irq, e);
    endtask : irq_is
    // divisor 2 gives 32 clocks a bit
    task automatic txone(input logic p, input logic [31:0] c, d,
                         input int nb);
        logic [9:0] ch;
        pos <= p;
        apb(1, `SBG_OFF_CTRL, c);
        apb(1, `SBG_OFF_TXDATA, d);
        u_node.get_char(32, nb, ch);
        chk("frame", ch & ((2 << nb) - 1), (d & ((1 << nb) - 1)) | (1 << nb));
    endtask : txone
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `SBG_OFF_BAUD_HI, 0);
        chk("hi", rd, 32'h0);
        apb(0, `SBG_OFF_BAUD_LO, 0);
        chk("lo", rd, 32'h4);
        apb(0, 12'h01c, 0);
        chk("slverr", er, 1);
        no_ticks();
        apb(1, `SBG_OFF_CTRL, 32'h01);
        period(n);
        chk("per4", n, 4);
        apb(1, `SBG_OFF_BAUD_HI, 32'h01);
        period(n);
        chk("perbuf", n, 4);
        apb(1, `SBG_OFF_BAUD_LO, 32'h02);
        period(n);
        chk("per258", n, 258);
        apb(1, `SBG_OFF_BAUD_HI, 32'h00);
        apb(1, `SBG_OFF_BAUD_LO, 32'h00);
        no_ticks();
        apb(1, `SBG_OFF_BAUD_LO, 32'h02);
        period(n);
        chk("per2", n, 2);
        txone(0, 32'h03, 32'h0a5, 8);
        txone(1, 32'h23, 32'h03c, 8);
        u_node.put_char(32, 8, 9'h0a6);
        apb(0, `SBG_OFF_RXDATA, 0);
        chk("rx_alt", rd, 32'h0a6);
        txone(0, 32'h07, 32'h15a, 9);
        u_node.put_char(32, 9, 9'h1c3);
        apb(0, `SBG_OFF_RXDATA, 0);
        chk("rx9", rd, 32'h1c3);
        apb(0, `SBG_OFF_STATUS, 0);
        chk("rxdone", rd & 32'h4, 32'h4);
        apb(1, `SBG_OFF_CTRL, 32'h11);
        apb(1, `SBG_OFF_STATUS, 32'h0f);
        u_node.hold_low(9 * 32);
        repeat (64) @(posedge pclk);
        apb(0, `SBG_OFF_STATUS, 0);
        chk("short", rd & 1, 0);
        u_node.hold_low(12 * 32);
        repeat (64) @(posedge pclk);
        apb(0, `SBG_OFF_STATUS, 0);
        chk("brk", rd & 3, 3);
        irq_is(0);
        apb(1, `SBG_OFF_BAUD_HI, 32'h80);
        irq_is(1);
        apb(1, `SBG_OFF_BAUD_HI, 32'h40);
        irq_is(1);
        apb(1, `SBG_OFF_STATUS, 32'h02);
        irq_is(0);
        apb(1, `SBG_OFF_MASK, 32'h01);
        irq_is(1);
        apb(1, `SBG_OFF_STATUS, 32'h01);
        irq_is(0);
        apb(1, `SBG_OFF_CTRL, 32'h0a);
        fork
            begin
                repeat (100) @(posedge pclk);
                apb(1, `SBG_OFF_CTRL, 32'h02);
            end
            begin
                w = 0;
                n = 0;
                while (od !== 1'b0 && w < 2000) @(posedge pclk) w++;
                while (od === 1'b0 && n < 3000) @(posedge pclk) n++;
            end
        join
        chk("brklen", n, `SBG_BRK_TX_BITS * `SBG_OVERSAMPLE * 2);
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end
endmodule : sbg_baud_gen_tb
